//--- hw/fcs_pkg.sv
// shared constants, types and register map for the flash command host
package fcs_pkg;
    // clock and bus timing, times in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WE_LOW_NS   = 50;
    localparam int T_WE_HIGH_NS  = 30;
    localparam int T_ACC_NS      = 100;
    localparam int WE_LOW_CYC    = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_HIGH_CYC   = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_OP_LSB    = 1;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_READY_BIT   = 1;
    localparam int ST_DONE_BIT    = 2;
    localparam int ST_FAIL_BIT    = 3;
    localparam int POLL_BIT       = 7;
    localparam int TIMEOUT_BIT    = 5;
    // command codes and unlock addresses (word mode)
    localparam logic [7:0]  CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0]  CMD_IDENT   = 8'h90;
    localparam logic [7:0]  CMD_PROG    = 8'hA0;
    localparam logic [7:0]  CMD_ERASE   = 8'h80;
    localparam logic [7:0]  CMD_CHIP    = 8'h10;
    localparam logic [7:0]  CMD_SECT    = 8'h30;
    localparam logic [7:0]  CMD_SUSP    = 8'hB0;
    localparam logic [7:0]  CMD_RESUME  = 8'h30;
    localparam logic [7:0]  CMD_RESET   = 8'hF0;
    localparam logic [11:0] UNLOCK_A1   = 12'h555;
    localparam logic [11:0] UNLOCK_A2   = 12'h2AA;
    typedef enum logic [2:0] {
        OP_READ = 3'h0, OP_RESET = 3'h1, OP_IDENT = 3'h2, OP_PROG = 3'h3,
        OP_CHIP = 3'h4, OP_SECT = 3'h5, OP_SUSP = 3'h6, OP_RESUME = 3'h7
    } fcs_op_t;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_WSET = 6'h02, S_WLOW = 6'h04,
        S_WHIGH = 6'h08, S_RLOW = 6'h10, S_EVAL = 6'h20
    } fcs_state_t;
    // one bus write of a command sequence
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
        logic        useAddr;
        logic        useData;
    } fcs_step_t;
    // flash strobes, all active low
    typedef struct packed {
        logic ceN;
        logic weN;
        logic oeN;
    } fcs_strobe_t;
endpackage : fcs_pkg

//--- hw/fcs_host.sv
// flash command host: AHB-Lite registers, command sequencer and status polling
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
// Notes on behaviour
// - Reset code F0 returns to array reads; host sends it after a failed poll.
// - Identification: AA, 55, 90 at unlock addresses, then a read.
// - Program: two unlocks, A0 at unlock address, data at target.
// - Erase: unlock, unlock, 80, unlock, unlock, then 10 at unlock address or 30 at sector.
// - Program status is polled at the program address.
// - Erase status is polled inside a sector selected for erase.
// - After the polling bit turns true, valid data comes on the next read.
// - After the timeout flag is seen, the polling bit is read again.
module fcs_host #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                resetn,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // flash pins
    output fcs_pkg::fcs_strobe_t     flashStrobe,
    output logic [ADDR_W-1:0]        flashAddr,
    input  wire logic [15:0]         dqIn,
    output logic [15:0]              dqOut,
    output logic                     dqOe,
    input  wire logic                busyOdIn
);
    ////////////////////////////////////////////////////////////////////////
    // parameter check: the unlock addresses need twelve address bits
    if (ADDR_W < 12 || ADDR_W > 32) begin : gBadAddrW
        $error("ADDR_W must lie between 12 and 32");
    end
    ////////////////////////////////////////////////////////////////////////
    // state
    fcs_pkg::fcs_state_t  stateQ;
    fcs_pkg::fcs_op_t     opQ;
    fcs_pkg::fcs_strobe_t strobeQ;
    logic [3:0]           cntQ;
    logic [2:0]           stepQ;
    logic [ADDR_W-1:0]    addrQ;
    logic [ADDR_W-1:0]    faddrQ;
    logic [15:0]          wdataQ;
    logic [15:0]          rdataQ;
    logic [15:0]          dqOutQ;
    logic                 dqOeQ;
    logic                 doneQ;
    logic                 failQ;
    logic                 finalQ;
    logic                 toSeenQ;
    logic                 selQ;
    logic                 wrQ;
    logic [7:0]           regQ;
    logic [31:0]          hrdataQ;

    ////////////////////////////////////////////////////////////////////////
    // command tables
    function automatic fcs_pkg::fcs_step_t stepOf(input fcs_pkg::fcs_op_t op, input logic [2:0] idx);
        fcs_pkg::fcs_step_t s;
        s = '{addr: fcs_pkg::UNLOCK_A1, data: fcs_pkg::CMD_UNLOCK1, useAddr: 1'b0, useData: 1'b0};
        case (op)
            fcs_pkg::OP_RESET:  s.data = fcs_pkg::CMD_RESET;
            fcs_pkg::OP_SUSP:   s.data = fcs_pkg::CMD_SUSP;
            fcs_pkg::OP_RESUME: s.data = fcs_pkg::CMD_RESUME;
            default: begin
                case (idx)
                    3'h1, 3'h4: begin
                        s.addr = fcs_pkg::UNLOCK_A2;
                        s.data = fcs_pkg::CMD_UNLOCK2;
                    end
                    3'h2: begin
                        s.data = (op == fcs_pkg::OP_IDENT) ? fcs_pkg::CMD_IDENT :
                                 (op == fcs_pkg::OP_PROG)  ? fcs_pkg::CMD_PROG :
                                                             fcs_pkg::CMD_ERASE;
                    end
                    3'h3: begin
                        s.useAddr = (op == fcs_pkg::OP_PROG);
                        s.useData = (op == fcs_pkg::OP_PROG);
                    end
                    3'h5: begin
                        s.useAddr = (op == fcs_pkg::OP_SECT);
                        s.data    = (op == fcs_pkg::OP_SECT) ? fcs_pkg::CMD_SECT : fcs_pkg::CMD_CHIP;
                    end
                    default: s.data = fcs_pkg::CMD_UNLOCK1;
                endcase
            end
        endcase
        return s;
    endfunction : stepOf
    // number of writes before the read phase
    function automatic logic [2:0] nWrites(input fcs_pkg::fcs_op_t op);
        case (op)
            fcs_pkg::OP_READ:  return 3'h0;
            fcs_pkg::OP_IDENT: return 3'h3;
            fcs_pkg::OP_PROG:  return 3'h4;
            fcs_pkg::OP_CHIP,
            fcs_pkg::OP_SECT:  return 3'h6;
            default:           return 3'h1;
        endcase
    endfunction : nWrites
    ////////////////////////////////////////////////////////////////////////
    // decode
    wire                 accept   = hsel & htrans[1] & hready;
    wire                 regWr    = selQ & wrQ;
    wire                 startReq = regWr & (regQ == fcs_pkg::REG_CTRL) & hwdata[fcs_pkg::CTRL_START_BIT];
    wire fcs_pkg::fcs_op_t opReq  = fcs_pkg::fcs_op_t'(hwdata[fcs_pkg::CTRL_OP_LSB +: 3]);
    wire                 isIdle   = (stateQ == fcs_pkg::S_IDLE);
    wire                 pollOp   = (opQ == fcs_pkg::OP_PROG) | (opQ == fcs_pkg::OP_CHIP) | (opQ == fcs_pkg::OP_SECT);
    wire                 readOp   = pollOp | (opQ == fcs_pkg::OP_READ) | (opQ == fcs_pkg::OP_IDENT);
    wire [2:0]           stepNxt  = 3'(stepQ + 3'h1);
    wire                 moreWr   = (stepNxt < nWrites(opQ));
    // erase expects 1, program expects true bit 7 of the data
    wire                 expBit   = (opQ == fcs_pkg::OP_PROG) ? wdataQ[fcs_pkg::POLL_BIT] : 1'b1;
    wire                 pollMatch = (rdataQ[fcs_pkg::POLL_BIT] == expBit);
    wire                 toFlag   = rdataQ[fcs_pkg::TIMEOUT_BIT];
    wire fcs_pkg::fcs_step_t stepStart = stepOf(opReq, 3'h0);
    wire fcs_pkg::fcs_step_t stepNext  = stepOf(opQ, stepNxt);
    wire fcs_pkg::fcs_step_t stepRst   = stepOf(fcs_pkg::OP_RESET, 3'h0);
    // a newly launched op may not see its own address write yet; software writes ADDR first
    wire fcs_pkg::fcs_step_t stepLoad  = isIdle ? stepStart : (stateQ == fcs_pkg::S_EVAL) ? stepRst : stepNext;
    wire [ADDR_W-1:0]    loadAddr = stepLoad.useAddr ? addrQ : ADDR_W'(stepLoad.addr);
    wire [15:0]          loadData = stepLoad.useData ? wdataQ : {8'h00, stepLoad.data};
    wire [31:0]          statusWord = {28'h0000000, failQ, doneQ, busyOdIn, ~isIdle};
    wire [7:0]           rdSel    = haddr[7:0];
    wire [31:0]          rdMux    = (rdSel == fcs_pkg::REG_CTRL)   ? {28'h0000000, opQ, 1'b0} :
                                    (rdSel == fcs_pkg::REG_ADDR)   ? 32'(addrQ) :
                                    (rdSel == fcs_pkg::REG_WDATA)  ? {16'h0000, wdataQ} :
                                    (rdSel == fcs_pkg::REG_STATUS) ? statusWord :
                                    (rdSel == fcs_pkg::REG_RDATA)  ? {16'h0000, rdataQ} : 32'h00000000;

    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = hrdataQ;
    assign flashStrobe = strobeQ;
    assign flashAddr   = faddrQ;
    assign dqOut       = dqOutQ;
    assign dqOe        = dqOeQ;

    ////////////////////////////////////////////////////////////////////////
    // bus address phase and register writes; hsize ignored, only words are used
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            selQ    <= 1'b0;
            wrQ     <= 1'b0;
            regQ    <= 8'h00;
            hrdataQ <= 32'h00000000;
            addrQ   <= '0;
            wdataQ  <= 16'h0000;
        end else begin
            selQ <= accept;
            wrQ  <= hwrite;
            regQ <= haddr[7:0];
            if (accept && !hwrite) hrdataQ <= rdMux;
            if (regWr && regQ == fcs_pkg::REG_ADDR) addrQ <= hwdata[ADDR_W-1:0];
            if (regWr && regQ == fcs_pkg::REG_WDATA) wdataQ <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer; a start while busy is dropped, and suspend state needs no guard here
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stateQ  <= fcs_pkg::S_IDLE;
            opQ     <= fcs_pkg::OP_READ;
            strobeQ <= 3'b111;
            cntQ    <= 4'h0;
            stepQ   <= 3'h0;
            faddrQ  <= '0;
            dqOutQ  <= 16'h0000;
            dqOeQ   <= 1'b0;
            rdataQ  <= 16'h0000;
            doneQ   <= 1'b0;
            failQ   <= 1'b0;
            finalQ  <= 1'b0;
            toSeenQ <= 1'b0;
        end else begin
            case (stateQ)
                fcs_pkg::S_IDLE: begin
                    if (startReq) begin
                        opQ     <= opReq;
                        stepQ   <= 3'h0;
                        doneQ   <= 1'b0;
                        failQ   <= 1'b0;
                        finalQ  <= 1'b0;
                        toSeenQ <= 1'b0;
                        if (opReq == fcs_pkg::OP_READ) begin
                            faddrQ  <= addrQ;
                            strobeQ <= 3'b010;
                            cntQ    <= 4'(fcs_pkg::ACC_CYC - 1);
                            stateQ  <= fcs_pkg::S_RLOW;
                        end else begin
                            faddrQ  <= loadAddr;
                            dqOutQ  <= loadData;
                            strobeQ <= 3'b011;
                            stateQ  <= fcs_pkg::S_WSET;
                        end
                    end
                end
                // address settles before the strobe falls
                fcs_pkg::S_WSET: begin
                    dqOeQ       <= 1'b1;
                    strobeQ.weN <= 1'b0;
                    cntQ        <= 4'(fcs_pkg::WE_LOW_CYC - 1);
                    stateQ      <= fcs_pkg::S_WLOW;
                end
                fcs_pkg::S_WLOW: begin
                    cntQ <= 4'(cntQ - 4'h1);
                    if (cntQ == 4'h0) begin
                        strobeQ <= 3'b111;
                        cntQ    <= 4'(fcs_pkg::WE_HIGH_CYC - 1);
                        stateQ  <= fcs_pkg::S_WHIGH;
                    end
                end
                // data kept on the bus through the rising edge
                fcs_pkg::S_WHIGH: begin
                    cntQ <= 4'(cntQ - 4'h1);
                    if (cntQ == 4'h0) begin
                        dqOeQ <= 1'b0;
                        if (moreWr) begin
                            stepQ   <= stepNxt;
                            faddrQ  <= loadAddr;
                            dqOutQ  <= loadData;
                            strobeQ <= 3'b011;
                            stateQ  <= fcs_pkg::S_WSET;
                        end else if (readOp) begin
                            faddrQ  <= addrQ;
                            strobeQ <= 3'b010;
                            cntQ    <= 4'(fcs_pkg::ACC_CYC - 1);
                            stateQ  <= fcs_pkg::S_RLOW;
                        end else begin
                            doneQ  <= 1'b1;
                            stateQ <= fcs_pkg::S_IDLE;
                        end
                    end
                end
                fcs_pkg::S_RLOW: begin
                    cntQ <= 4'(cntQ - 4'h1);
                    if (cntQ == 4'h0) begin
                        rdataQ  <= dqIn;
                        strobeQ <= 3'b111;
                        stateQ  <= fcs_pkg::S_EVAL;
                    end
                end
                // poll result; protected targets end as array reads that match
                fcs_pkg::S_EVAL: begin
                    if (!pollOp || (pollMatch && finalQ)) begin
                        doneQ  <= 1'b1;
                        stateQ <= fcs_pkg::S_IDLE;
                    end else if (!pollMatch && toFlag && toSeenQ) begin
                        failQ   <= 1'b1;
                        opQ     <= fcs_pkg::OP_RESET;
                        stepQ   <= 3'h0;
                        faddrQ  <= loadAddr;
                        dqOutQ  <= loadData;
                        strobeQ <= 3'b011;
                        stateQ  <= fcs_pkg::S_WSET;
                    end else begin
                        if (pollMatch) finalQ <= 1'b1;
                        if (toFlag) toSeenQ <= 1'b1;
                        strobeQ <= 3'b010;
                        cntQ    <= 4'(fcs_pkg::ACC_CYC - 1);
                        stateQ  <= fcs_pkg::S_RLOW;
                    end
                end
                default: stateQ <= fcs_pkg::S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire weLow = !strobeQ.weN;

    AST_WE_NEEDS_CE: assert property (weLow |-> !strobeQ.ceN && $past(!strobeQ.ceN))
        else $error("write strobe low without prior select");
    AST_WE_WIDTH: assert property ($fell(strobeQ.weN) |-> weLow[*5] ##1 !weLow)
        else $error("write pulse width wrong");
    AST_DATA_HELD: assert property ($rose(strobeQ.weN) |-> dqOeQ && $stable(dqOutQ))
        else $error("data not held at strobe rise");
    AST_NO_RW_OVERLAP: assert property (!(weLow && !strobeQ.oeN))
        else $error("read and write strobes overlap");
    AST_UPPER_ZERO: assert property ((weLow && !(opQ == fcs_pkg::OP_PROG && stepQ == 3'h3))
        |-> dqOutQ[15:8] == 8'h00)
        else $error("upper byte set in command cycle");
    AST_PROG_SETUP: assert property ((weLow && opQ == fcs_pkg::OP_PROG && stepQ == 3'h2)
        |-> dqOutQ[7:0] == 8'hA0 && faddrQ[11:0] == 12'h555)
        else $error("program setup cycle wrong");
    AST_PROG_DATA: assert property ((weLow && opQ == fcs_pkg::OP_PROG && stepQ == 3'h3)
        |-> dqOutQ == wdataQ && faddrQ == addrQ)
        else $error("program data cycle wrong");
    AST_IDENT_CMD: assert property ((weLow && opQ == fcs_pkg::OP_IDENT && stepQ == 3'h2)
        |-> dqOutQ[7:0] == 8'h90)
        else $error("identification command wrong");
    AST_CHIP_LAST: assert property ((weLow && opQ == fcs_pkg::OP_CHIP && stepQ == 3'h5)
        |-> dqOutQ[7:0] == 8'h10 && faddrQ[11:0] == 12'h555)
        else $error("chip erase final cycle wrong");
    AST_SECT_LAST: assert property ((weLow && opQ == fcs_pkg::OP_SECT && stepQ == 3'h5)
        |-> dqOutQ[7:0] == 8'h30 && faddrQ == addrQ)
        else $error("sector erase final cycle wrong");
    AST_SUSPEND: assert property ((weLow && opQ == fcs_pkg::OP_SUSP) |-> dqOutQ[7:0] == 8'hB0 && stepQ == 3'h0)
        else $error("suspend write wrong");
    AST_RESUME: assert property ((weLow && opQ == fcs_pkg::OP_RESUME) |-> dqOutQ[7:0] == 8'h30 && stepQ == 3'h0)
        else $error("resume write wrong");
    AST_POLL_ADDR: assert property ((!strobeQ.oeN && pollOp) |-> faddrQ == addrQ)
        else $error("poll read at wrong address");
    AST_FINAL_READ: assert property (($rose(doneQ) && pollOp) |-> $past(finalQ))
        else $error("poll done without confirming read");
    AST_FAIL_REREAD: assert property ($rose(failQ) |-> $past(toSeenQ))
        else $error("fail without re-read after timeout flag");
    AST_FAIL_RESET: assert property ($rose(failQ) |-> ##[1:12] (weLow && dqOutQ[7:0] == 8'hF0))
        else $error("no reset command after failure");
    COV_PROG_DONE: cover property ($rose(doneQ) && opQ == fcs_pkg::OP_PROG);
    COV_SECT_DONE: cover property ($rose(doneQ) && opQ == fcs_pkg::OP_SECT);
    COV_FAIL:      cover property ($rose(failQ));
    COV_IDENT:     cover property ($rose(doneQ) && opQ == fcs_pkg::OP_IDENT);
endmodule : fcs_host

//--- testbench/fcs_flash_model.sv
// behavioural flash device answering the command host
`timescale 1ns/1ns
module fcs_flash_model #(
    parameter logic [15:0] MAKER_ID  = 16'h00A5, // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h5A5A, // arbitrary value
    parameter logic [5:0]  PROT_SEC  = 6'h3F,
    parameter int          PROG_CYC  = 40,
    parameter int          ERASE_CYC = 300
) (
    // host pins
    input  wire fcs_pkg::fcs_strobe_t flashStrobe,
    input  wire logic [17:0]          flashAddr,
    input  wire logic [15:0]          dqOut,
    // device outputs
    output logic [15:0]               dqIn,
    output wire logic                 busyLine
);
    logic [15:0] mem [logic [17:0]];
    logic [17:0] la;
    logic [7:0]  ld;
    logic [2:0]  st = 3'h0;
    logic        ident = 1'h0, susp = 1'h0, chip = 1'h0, pBit = 1'h0, fail = 1'h0;
    logic [5:0]  eSec = 6'h0;
    int          pl = 0, el = 0;
    wire         wrN = flashStrobe.ceN | flashStrobe.weN;
    wire         rdN = flashStrobe.ceN | flashStrobe.oeN;
    wire         prot = la[17:12] == PROT_SEC;
    wire         erRd = el > 0 && (chip || flashAddr[17:12] == eSec);
    // address on the later falling edge
    always @(negedge wrN) la = flashAddr;
    // data on the first rising edge, then the command decoder
    always @(posedge wrN) begin
        ld = dqOut[7:0];
        if (pl > 0 || $isunknown({la, ld})) st = 3'h0;
        else if (ld == 8'hF0) begin st = 3'h0; ident = 1'h0; fail = 1'h0; end
        else if (ld == 8'hB0) susp = el > 0 && !chip;
        else if (el > 0 && !susp) st = 3'h0;
        else if (ld == 8'h30 && susp && st == 3'h0) susp = 1'h0;
        else case (st)
            3'h0, 3'h3: st = (la[10:0] == 11'h555 && ld == 8'hAA) ? st + 3'h1 : 3'h0;
            3'h1, 3'h4: st = (la[10:0] == 11'h2AA && ld == 8'h55) ? st + 3'h1 : 3'h0;
            3'h2: begin
                ident = ld == 8'h90;
                st = ld == 8'h80 ? 3'h3 : ld == 8'hA0 ? 3'h6 : 3'h0;
            end
            3'h5: begin
                st = 3'h0;
                if (ld == 8'h10 || ld == 8'h30) begin
                    chip = ld == 8'h10;
                    eSec = la[17:12];
                    el = (chip || !prot) ? ERASE_CYC : 10000;
                    foreach (mem[k]) if (k[17:12] != PROT_SEC && (chip || k[17:12] == eSec)) mem[k] = 16'hFFFF;
                end
            end
            default: begin
                st = 3'h0;
                pBit = dqOut[7];
                // a one over a stored zero cannot be programmed: stall with the timeout flag up
                fail = mem.exists(la) && (dqOut & ~mem[la]) != 16'h0;
                pl = fail ? 0 : prot ? 100 : PROG_CYC;
                if (!prot && !fail) mem[la] = dqOut;
            end
        endcase
    end
    // embedded time base, erase frozen while suspended
    always #10 begin
        if (pl > 0) pl--;
        else if (el > 0 && !susp) el--;
    end
    // read path off the clock edges; a released bus toggles so stale data never passes
    initial begin
        dqIn = 16'h0000;
        #2;
        forever begin
            #5;
            if (rdN) dqIn = ~dqIn;
            else if (ident) dqIn = flashAddr[7:0] == 8'h00 ? MAKER_ID : flashAddr[7:0] == 8'h01 ? DEVICE_ID
                : {15'h0, flashAddr[17:12] == PROT_SEC};
            else if (fail) dqIn = {8'h00, ~pBit, 1'h0, 1'h1, 5'h00};
            else if (pl > 0) dqIn = {8'h00, ~pBit, 7'h00};
            else if (erRd) dqIn = {8'h00, susp, 7'h00};
            else dqIn = mem.exists(flashAddr) ? mem[flashAddr] : 16'hFFFF;
        end
    end
    // open drain: pulls low only while an algorithm runs
    assign busyLine = (pl > 0 || (el > 0 && !susp)) ? 1'b0 : 1'bz;
endmodule : fcs_flash_model

//--- testbench/tb_fcs_host.sv
// self-checking bench for the flash command host
`timescale 1ns/1ns
module tb_fcs_host;
    logic                 core_clk = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, sawBusy;
    logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, st;
    logic [1:0]           htrans = 2'h0;
    logic [2:0]           hsize = 3'h2;
    logic                 hreadyout, hresp, dqOe;
    logic [17:0]          flashAddr;
    logic [15:0]          dqIn, dqOut;
    fcs_pkg::fcs_strobe_t flashStrobe;
    tri1                  busyLine;
    int                   bad_count = 0, samples_checked = 0, cyc;
    always #5 core_clk = ~core_clk;
    fcs_host DUT (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .flashStrobe(flashStrobe), .flashAddr(flashAddr), .dqIn(dqIn),
        .dqOut(dqOut), .dqOe(dqOe), .busyOdIn(busyLine));
    fcs_flash_model #(.MAKER_ID(16'h00A5), .DEVICE_ID(16'h5A5A)) FLASH (.flashStrobe(flashStrobe),
        .flashAddr(flashAddr), .dqOut(dqOut), .dqIn(dqIn), .busyLine(busyLine));
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h", $time, msg, got);
        end
    endtask : chk
    // a stuck bus must not hang the run
    task rdyEdge;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin bad_count++; end_of_test; end
    endtask : rdyEdge
    // one single AHB-Lite transfer, entered just after a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        rdyEdge;
        hsel <= 1'h0; htrans <= 2'h0; hwdata <= wd;
        rdyEdge;
        rd = hrdata;
    endtask : bus
    // start an operation, poll status under a bound, return the last flash word
    task runOp(input logic [2:0] o, input logic [17:0] a, input logic [15:0] d, output logic [31:0] rd);
        logic [31:0] s;
        sawBusy = 1'h0;
        bus(1'h1, fcs_pkg::REG_ADDR, {14'h0, a}, s);
        bus(1'h1, fcs_pkg::REG_WDATA, {16'h0, d}, s);
        bus(1'h1, fcs_pkg::REG_CTRL, {28'h0, o, 1'h1}, s);
        cyc = 0;
        do begin
            bus(1'h0, fcs_pkg::REG_STATUS, 32'h0, st);
            cyc++;
            if (st[fcs_pkg::ST_READY_BIT] === 1'b0) sawBusy = 1'h1;
        end while (st[fcs_pkg::ST_DONE_BIT] !== 1'b1 && cyc < 8000);
        if (st[fcs_pkg::ST_DONE_BIT] !== 1'b1) begin bad_count++; end_of_test; end
        bus(1'h0, fcs_pkg::REG_RDATA, 32'h0, rd);
    endtask : runOp
    ////////////////////////////////////////////////////////////////////////////////
    task t_program;
        logic [31:0] r;
        runOp(3'h0, 18'h00010, 16'h0, r);
        chk(r, 32'h0000FFFF, "blank read");
        bus(1'h0, 8'h20, 32'h0, r);
        chk(r, 32'h0, "unmapped read");
        chk({30'h0, hresp, dqOe}, 32'h0, "idle bus and pins");
        for (int i = 0; i < 2; i++) begin
            runOp(3'h3, 18'h00010 + i, i ? 16'hBEEF : 16'h1234, r);
            chk({29'h0, st[3:2], sawBusy}, 32'h3, "program status");
            runOp(3'h0, 18'h00010 + i, 16'h0, r);
            chk(r, i ? 32'hBEEF : 32'h1234, "program readback");
        end
        // programming ones over zeros stalls with the timeout flag; host re-reads, fails and resets
        runOp(3'h3, 18'h00010, 16'h00FF, r);
        chk({30'h0, st[3:2]}, 32'h3, "failed program");
    endtask : t_program
    task t_ident;
        logic [31:0] r;
        logic [17:0] ad [4] = '{18'h0, 18'h1, 18'h3F002, 18'h01002};
        logic [15:0] ex [4] = '{16'h00A5, 16'h5A5A, 16'h0001, 16'h0000};
        foreach (ad[i]) begin
            runOp(3'h2, ad[i], 16'h0, r);
            chk(r, {16'h0, ex[i]}, "identify");
        end
        runOp(3'h1, 18'h0, 16'h0, r);
        runOp(3'h0, 18'h00010, 16'h0, r);
        chk(r, 32'h1234, "reset to array");
        runOp(3'h6, 18'h0, 16'h0, r);
        runOp(3'h7, 18'h0, 16'h0, r);
        runOp(3'h0, 18'h00011, 16'h0, r);
        chk(r, 32'hBEEF, "stray suspend resume");
    endtask : t_ident
    task t_erase;
        logic [31:0] r;
        runOp(3'h3, 18'h3F000, 16'h0080, r);
        chk({r[15:0], 15'h0, cyc >= 60}, 32'hFFFF0001, "protected program");
        runOp(3'h5, 18'h00010, 16'h0, r);
        chk({31'h0, sawBusy}, 32'h1, "sector erase busy");
        runOp(3'h0, 18'h00011, 16'h0, r);
        chk(r, 32'hFFFF, "sector erased");
        runOp(3'h3, 18'h01000, 16'h1234, r);
        runOp(3'h4, 18'h01000, 16'h0, r);
        runOp(3'h0, 18'h01000, 16'h0, r);
        chk(r, 32'hFFFF, "chip erased");
        runOp(3'h5, 18'h3F000, 16'h0, r);
        chk({31'h0, cyc >= 4900}, 32'h1, "protected erase time");
    endtask : t_erase
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'h1;
        @(posedge core_clk);
        t_program;
        t_ident;
        t_erase;
        end_of_test;
    end
endmodule : tb_fcs_host
